// ==== cvc_crtc.sv ====
`default_nettype none
module cvc_crtc #(
  parameter int H_TOTAL_CHARS = 100,
  parameter int H_ACTIVE_CHARS = 80
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [7:0] reg_index,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic vsync,
  output logic vertical_irq,
  output logic display_en,
  output logic [20:0] mem_addr,
  output logic cursor,
  output logic underline,
  output logic [2:0] refresh_count
);
  import cvc_pkg::*;

  localparam int H_W = $clog2(H_TOTAL_CHARS);

  if (H_ACTIVE_CHARS < 1 || H_ACTIVE_CHARS >= H_TOTAL_CHARS) begin : g_bad_timing
    $error("cvc_crtc: active characters must be below total characters");
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] slot_of(input logic [7:0] idx);
    case (idx)
      IDX_VTOTAL: slot_of = {1'b1, SL_VTOTAL};
      IDX_OVFL: slot_of = {1'b1, SL_OVFL};
      IDX_MAXSCAN: slot_of = {1'b1, SL_MAXSCAN};
      IDX_CUR_START: slot_of = {1'b1, SL_CUR_START};
      IDX_CUR_END: slot_of = {1'b1, SL_CUR_END};
      IDX_START_HI: slot_of = {1'b1, SL_START_HI};
      IDX_START_LO: slot_of = {1'b1, SL_START_LO};
      IDX_CUR_HI: slot_of = {1'b1, SL_CUR_HI};
      IDX_CUR_LO: slot_of = {1'b1, SL_CUR_LO};
      IDX_VS_START: slot_of = {1'b1, SL_VS_START};
      IDX_VS_END: slot_of = {1'b1, SL_VS_END};
      IDX_VDE: slot_of = {1'b1, SL_VDE};
      IDX_OFFSET: slot_of = {1'b1, SL_OFFSET};
      IDX_ULINE: slot_of = {1'b1, SL_ULINE};
      IDX_MODE: slot_of = {1'b1, SL_MODE};
      IDX_MEMCFG: slot_of = {1'b1, SL_MEMCFG};
      IDX_SYSCFG: slot_of = {1'b1, SL_SYSCFG};
      IDX_REFOVR: slot_of = {1'b1, SL_REFOVR};
      IDX_EXTMODE: slot_of = {1'b1, SL_EXTMODE};
      IDX_PITCH_EXT: slot_of = {1'b1, SL_PITCH_EXT};
      IDX_VEXT: slot_of = {1'b1, SL_VEXT};
      IDX_ADDR_EXT: slot_of = {1'b1, SL_ADDR_EXT};
      default: slot_of = 6'h00;
    endcase
  endfunction

  function automatic logic [7:0] base_mask(input logic [4:0] sl);
    case (sl)
      SL_CUR_START: base_mask = MASK_CUR_START;
      SL_CUR_END: base_mask = MASK_CUR_END;
      SL_ULINE: base_mask = MASK_ULINE;
      SL_MODE: base_mask = MASK_MODE;
      default: base_mask = MASK_FULL;
    endcase
  endfunction

  function automatic logic [20:0] shl_mode(input logic [20:0] v, input cvc_addr_mode_t m);
    case (m)
      AM_QWORD: shl_mode = v << 3;
      AM_DWORD: shl_mode = v << 2;
      AM_WORD: shl_mode = v << 1;
      default: shl_mode = v;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register file
  logic [7:0] cr [NUM_SLOTS];
  logic [5:0] hit;
  logic [4:0] slot;
  logic locked;
  logic [7:0] wmask;

  assign hit = slot_of(reg_index);
  assign slot = hit[4:0];
  assign locked = cr[SL_VS_END][B_LOCK];

  always_comb begin
    wmask = base_mask(slot);
    if (locked && reg_index <= IDX_LOCK_LAST) begin
      wmask = (slot == SL_OVFL) ? MASK_SPLIT8 : MASK_NONE;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_SLOTS; i++) begin
        cr[i] <= RST_REG;
      end
    end else if (reg_wr && hit[5]) begin
      cr[slot] <= (cr[slot] & ~wmask) | (reg_wdata & wmask);
    end
  end

  // Reserved bits are never stored, so they read back as zero
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= hit[5] ? cr[slot] : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assembled fields
  logic [10:0] vtotal;
  logic [10:0] vde_val;
  logic [10:0] vrs_val;
  logic [3:0] vre_val;
  logic [20:0] start_addr;
  logic [20:0] cur_loc;
  logic [9:0] off10;
  logic [4:0] maxscan;
  logic [4:0] cstart;
  logic [4:0] cend;
  logic [1:0] cur_skew;
  logic cur_off;
  logic clr_bit;
  logic dis_bit;
  logic gie;
  logic cnt4;
  logic cnt2;
  cvc_addr_mode_t amode;
  logic [20:0] pitch;

  assign vtotal = {cr[SL_VEXT][B_EXT_VT10], cr[SL_OVFL][B_OVF_VT9],
                   cr[SL_OVFL][B_OVF_VT8], cr[SL_VTOTAL]};
  assign vde_val = {cr[SL_VEXT][B_EXT_VDE10], cr[SL_OVFL][B_OVF_VDE9],
                    cr[SL_OVFL][B_OVF_VDE8], cr[SL_VDE]};
  assign vrs_val = {cr[SL_VEXT][B_EXT_VRS10], cr[SL_OVFL][B_OVF_VRS9],
                    cr[SL_OVFL][B_OVF_VRS8], cr[SL_VS_START]};
  assign vre_val = cr[SL_VS_END][3:0];
  assign start_addr = {cr[SL_ADDR_EXT][4:0], cr[SL_START_HI], cr[SL_START_LO]};
  assign cur_loc = {cr[SL_ADDR_EXT][4:0], cr[SL_CUR_HI], cr[SL_CUR_LO]};
  assign off10 = (cr[SL_PITCH_EXT][5:4] == 2'b00) ?
                 {1'b0, cr[SL_EXTMODE][B_PITCH8], cr[SL_OFFSET]} :
                 {cr[SL_PITCH_EXT][5:4], cr[SL_OFFSET]};
  assign maxscan = cr[SL_MAXSCAN][4:0];
  assign cstart = cr[SL_CUR_START][4:0];
  assign cend = cr[SL_CUR_END][4:0];
  assign cur_skew = cr[SL_CUR_END][6:5];
  assign cur_off = cr[SL_CUR_START][B_CUR_OFF];
  assign clr_bit = cr[SL_VS_END][B_VINT_CLR];
  assign dis_bit = cr[SL_VS_END][B_VINT_DIS];
  assign gie = cr[SL_SYSCFG][B_GIE];
  assign cnt4 = cr[SL_ULINE][B_CNT4];
  assign cnt2 = cr[SL_MODE][B_CNT2];

  always_comb begin
    if (cr[SL_MEMCFG][B_FORCE_DW]) begin
      amode = AM_DWORD;
    end else if (cr[SL_ULINE][B_DWORD]) begin
      amode = cnt4 ? AM_QWORD : AM_DWORD;
    end else if (cnt2) begin
      amode = AM_WORD;
    end else begin
      amode = AM_BYTE;
    end
  end

  // Byte mode still steps rows by two, as word mode does
  assign pitch = shl_mode({11'h000, off10}, (amode == AM_BYTE) ? AM_WORD : amode);

  ////////////////////////////////////////////////////////////////////////////
  // Horizontal and vertical counters
  logic [H_W-1:0] hcount;
  logic [10:0] vcount;
  logic [4:0] rowscan;
  logic line_end;
  logic frame_wrap;
  logic row_end;
  logic h_active;
  logic v_active;
  logic act;

  assign line_end = (hcount == H_W'(H_TOTAL_CHARS - 1));
  assign frame_wrap = line_end && (vcount == vtotal);
  assign row_end = line_end && (rowscan == maxscan);
  assign h_active = (hcount < H_W'(H_ACTIVE_CHARS));
  assign v_active = (vcount <= vde_val);
  assign act = h_active && v_active;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      hcount <= '0;
    end else begin
      hcount <= line_end ? '0 : hcount + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      vcount <= 11'h000;
      rowscan <= 5'h00;
    end else if (line_end) begin
      vcount <= frame_wrap ? 11'h000 : vcount + 11'h001;
      rowscan <= (frame_wrap || rowscan == maxscan) ? 5'h00 : rowscan + 5'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Memory address counter
  logic [20:0] ma_row;
  logic [20:0] ma;
  logic [1:0] ma_div;
  logic [1:0] div_last;
  logic [20:0] next_row;

  assign div_last = cnt4 ? 2'd3 : (cnt2 ? 2'd1 : 2'd0);
  assign next_row = frame_wrap ? start_addr : (row_end ? ma_row + pitch : ma_row);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ma_row <= 21'h000000;
    end else if (line_end) begin
      ma_row <= next_row;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ma <= 21'h000000;
      ma_div <= 2'd0;
    end else if (line_end) begin
      ma <= next_row;
      ma_div <= 2'd0;
    end else if (h_active) begin
      ma_div <= (ma_div >= div_last) ? 2'd0 : ma_div + 2'd1;
      if (ma_div >= div_last) begin
        ma <= ma + 21'h000001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      mem_addr <= 21'h000000;
      display_en <= 1'b0;
    end else begin
      mem_addr <= shl_mode(ma, amode);
      display_en <= act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Vertical sync; start wins when both match on one line
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      vsync <= 1'b0;
    end else if (vcount == vrs_val) begin
      vsync <= 1'b1;
    end else if (vcount[3:0] == vre_val) begin
      vsync <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Vertical interrupt; a zero clear bit overrides a new request
  logic vint_ff;
  logic vde_end;

  assign vde_end = line_end && (vcount == vde_val);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      vint_ff <= 1'b0;
    end else if (!clr_bit) begin
      vint_ff <= 1'b0;
    end else if (vde_end) begin
      vint_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      vertical_irq <= 1'b0;
    end else begin
      vertical_irq <= vint_ff && !dis_bit && gie;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Cursor, skew and underline
  logic cur_hit;
  logic [2:0] cur_pipe;
  logic [3:0] cur_dly;

  // Start holds first row minus one; start above end can never match
  assign cur_hit = act && !cur_off && (ma == cur_loc) &&
                   ({1'b0, rowscan} > {1'b0, cstart}) && (rowscan <= cend);
  assign cur_dly = {cur_pipe, cur_hit};

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      cur_pipe <= 3'h0;
      cursor <= 1'b0;
    end else begin
      cur_pipe <= cur_dly[2:0];
      cursor <= cur_dly[cur_skew];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      underline <= 1'b0;
    end else begin
      underline <= act && (rowscan == cr[SL_ULINE][4:0] + 5'h01);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Refresh cycles per line
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      refresh_count <= REFRESH_FEW;
    end else begin
      case (cr[SL_REFOVR][1:0])
        2'b00: refresh_count <= cr[SL_VS_END][B_REF5] ? REFRESH_MANY : REFRESH_FEW;
        2'b01: refresh_count <= REFRESH_FEW;
        default: refresh_count <= REFRESH_MANY;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_skewed_hit;
    (cur_hit && cur_skew == 2'd3) ##1 (cur_skew == 2'd3) [*3];
  endsequence

  chk_vint_hold: assert property (!clr_bit |=> !vint_ff)
    else $error("interrupt flip-flop set while clear bit low");
  chk_vint_set: assert property (clr_bit && vde_end |=> vint_ff)
    else $error("interrupt flip-flop missed display end");
  chk_irq_gate: assert property (vertical_irq |-> $past(vint_ff && !dis_bit && gie))
    else $error("interrupt raised while gated off");
  chk_vsync_start: assert property (vcount == vrs_val |=> vsync)
    else $error("vsync not raised at retrace start");
  chk_vsync_end: assert property (vcount != vrs_val && vcount[3:0] == vre_val |=> !vsync)
    else $error("vsync not dropped at retrace end");
  chk_lock_vtotal: assert property (reg_wr && locked && reg_index == IDX_VTOTAL
                                    |=> $stable(cr[SL_VTOTAL]))
    else $error("locked timing register was written");
  chk_frame_wrap: assert property (frame_wrap |=> vcount == 11'h000 && rowscan == 5'h00)
    else $error("scan counter did not wrap at total");
  chk_start_load: assert property (frame_wrap |=> ma_row == $past(start_addr) && ma == ma_row)
    else $error("frame did not restart at start address");
  chk_row_pitch: assert property (row_end && !frame_wrap |=> ma_row == $past(ma_row + pitch))
    else $error("row start did not advance by pitch");
  chk_cursor_skew: assert property (s_skewed_hit |=> cursor)
    else $error("skewed cursor missing after three clocks");
  chk_cursor_off: assert property (cur_off [*5] |=> !cursor)
    else $error("cursor shown while disabled");
endmodule
`default_nettype wire

// ==== cvc_crtc_vertical_cursor_addressing_bench.sv ====
`default_nettype none
module cvc_crtc_vertical_cursor_addressing_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import cvc_pkg::*;
  logic clk_sys, rst_n, reg_wr, reg_rd, vsync, vertical_irq, display_en, cursor, underline;
  logic [7:0] reg_index, reg_wdata, reg_rdata;
  logic [20:0] mem_addr;
  logic [2:0] refresh_count;
  logic [15:0] frame_len, vs_width, vs_lead, de_cycles, cur_cycles, cur_pos, frames;
  int err_count = 0;
  int checks_done = 0;
  // Short lines keep a frame to a few hundred clocks
  cvc_crtc #(.H_TOTAL_CHARS(12), .H_ACTIVE_CHARS(8)) u_cvc_crtc (.clk_sys(clk_sys),
    .rst_n(rst_n), .reg_index(reg_index), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .vsync(vsync), .vertical_irq(vertical_irq),
    .display_en(display_en), .mem_addr(mem_addr), .cursor(cursor), .underline(underline),
    .refresh_count(refresh_count));
  cvc_monitor u_cvc_monitor (.clk_sys(clk_sys), .rst_n(rst_n), .vsync(vsync),
    .display_en(display_en), .cursor(cursor), .frame_len(frame_len), .vs_width(vs_width),
    .vs_lead(vs_lead), .de_cycles(de_cycles), .cur_cycles(cur_cycles), .cur_pos(cur_pos),
    .frames(frames));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Counts: %0d compares, %0d mismatches", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  // Extra idle edge after each strobe so no strobe is assigned twice in a step
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    reg_index = idx;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk_sys);
    #10;
    reg_wr = 1'b0;
    @(posedge clk_sys);
    #10;
  endtask
  task automatic rd(input logic [7:0] idx, output logic [7:0] d);
    reg_index = idx;
    reg_rd = 1'b1;
    @(posedge clk_sys);
    #10;
    reg_rd = 1'b0;
    d = reg_rdata;
    @(posedge clk_sys);
    #10;
  endtask
  task automatic wait_frames(input int n);
    logic [15:0] target;
    int k;
    target = frames + 16'(n);
    for (k = 0; k < 1000 * n && frames != target; k++) @(posedge clk_sys);
    #10;
    if (frames !== target) begin
      err_count++;
      $display("BAD %0t frame wait ran out", $time);
      complete_run();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_regs();
    logic [7:0] ridx [4] = '{IDX_CUR_START, IDX_CUR_END, IDX_ULINE, 8'hF0};
    logic [7:0] rexp [4] = '{8'h3F, 8'h7F, 8'h7F, 8'h00};
    logic [7:0] d;
    int i;
    check(16'(refresh_count), 16'h0003, "refresh at reset");
    for (i = 8'h0A; i <= 8'h14; i++) begin
      rd(8'(i), d);
      check(16'(d), 16'h0000, "reset value");
    end
    for (i = 0; i < 4; i++) begin
      wr(ridx[i], 8'hFF);
      rd(ridx[i], d);
      check(16'(d), 16'(rexp[i]), "reserved bits");
      wr(ridx[i], 8'h00);
    end
    $display("regs test ended");
  endtask
  task automatic test_lock();
    logic [7:0] d;
    wr(IDX_VTOTAL, 8'h14);
    wr(IDX_VS_END, 8'h80);
    wr(IDX_VTOTAL, 8'h55);
    rd(IDX_VTOTAL, d);
    check(16'(d), 16'h0014, "locked total");
    wr(IDX_OVFL, 8'hFF);
    rd(IDX_OVFL, d);
    check(16'(d), 16'h0010, "locked overflow");
    wr(IDX_VS_END, 8'h00);
    wr(IDX_OVFL, 8'h00);
    rd(IDX_OVFL, d);
    check(16'(d), 16'h0000, "unlocked overflow");
    $display("lock test ended");
  endtask
  // 21 lines of 12 clocks, 6 active lines, sync on lines 10 to 12
  task automatic test_vsync();
    wr(IDX_VS_START, 8'h0A);
    wr(IDX_VS_END, 8'h0D);
    wr(IDX_VDE, 8'h05);
    wait_frames(2);
    check(frame_len, 16'd252, "frame length");
    check(vs_width, 16'd36, "sync width");
    check(vs_lead, 16'd132, "sync to first line");
    check(de_cycles, 16'd48, "active cycles");
    $display("vsync test ended");
  endtask
  task automatic test_irq();
    wr(IDX_SYSCFG, 8'h10);
    wr(IDX_VS_END, 8'h1D);
    wait_frames(1);
    check(16'(vertical_irq), 16'h0001, "irq set");
    wr(IDX_VS_END, 8'h0D);
    repeat (3) @(posedge clk_sys);
    #10;
    check(16'(vertical_irq), 16'h0000, "irq cleared");
    wr(IDX_VS_END, 8'h1D);
    check(16'(vertical_irq), 16'h0000, "irq rearmed idle");
    wait_frames(1);
    check(16'(vertical_irq), 16'h0001, "irq again");
    wr(IDX_VS_END, 8'h0D);
    wr(IDX_VS_END, 8'h3D);
    wait_frames(1);
    check(16'(vertical_irq), 16'h0000, "irq disabled");
    wr(IDX_SYSCFG, 8'h00);
    wr(IDX_VS_END, 8'h0D);
    wr(IDX_VS_END, 8'h1D);
    wait_frames(1);
    check(16'(vertical_irq), 16'h0000, "irq no global");
    wr(IDX_VS_END, 8'h0D);
    $display("irq test ended");
  endtask
  task automatic test_refresh();
    logic [7:0] v11 [5] = '{8'h0D, 8'h4D, 8'h4D, 8'h0D, 8'h0D};
    logic [7:0] v3a [5] = '{8'h00, 8'h00, 8'h01, 8'h02, 8'h03};
    logic [2:0] exp [5] = '{3'h3, 3'h5, 3'h3, 3'h5, 3'h5};
    int i;
    for (i = 0; i < 5; i++) begin
      wr(IDX_REFOVR, v3a[i]);
      wr(IDX_VS_END, v11[i]);
      wait_frames(1);
      check(16'(refresh_count), 16'(exp[i]), "refresh count");
    end
    wr(IDX_REFOVR, 8'h00);
    wr(IDX_VS_END, 8'h0D);
    $display("refresh test ended");
  endtask
  task automatic cur_case(input logic [7:0] cs, input logic [7:0] ce, input logic [7:0] lo,
                          input logic [7:0] ext, input logic [15:0] n);
    wr(IDX_CUR_START, cs);
    wr(IDX_CUR_END, ce);
    wr(IDX_CUR_LO, lo);
    wr(IDX_ADDR_EXT, ext);
    wait_frames(2);
    check(cur_cycles, n, "cursor cycles");
  endtask
  // Four scan lines a row, eight bytes a row, cursor in column two
  task automatic test_cursor();
    logic [15:0] pos0;
    wr(IDX_MAXSCAN, 8'h03);
    wr(IDX_OFFSET, 8'h04);
    cur_case(8'h00, 8'h02, 8'h02, 8'h00, 16'd2);
    pos0 = cur_pos;
    cur_case(8'h00, 8'h62, 8'h02, 8'h00, 16'd2);
    check(cur_pos, pos0 + 16'd3, "skew shift");
    cur_case(8'h00, 8'h02, 8'h03, 8'h00, 16'd2);
    check(cur_pos, pos0 + 16'd1, "location shift");
    cur_case(8'h03, 8'h02, 8'h02, 8'h00, 16'd0);
    cur_case(8'h20, 8'h02, 8'h02, 8'h00, 16'd0);
    cur_case(8'h01, 8'h02, 8'h02, 8'h00, 16'd1);
    wr(IDX_START_LO, 8'h10);
    cur_case(8'h00, 8'h02, 8'h02, 8'h00, 16'd0);
    cur_case(8'h00, 8'h02, 8'h12, 8'h00, 16'd2);
    wr(IDX_START_LO, 8'h00);
    cur_case(8'h00, 8'h02, 8'h02, 8'h10, 16'd2);
    $display("cursor test ended");
  endtask
  task automatic addr_case(input logic [7:0] ul, input logic [7:0] md, input logic [7:0] cfg,
                           input logic [15:0] a0, input logic [15:0] a1);
    int k;
    int n;
    wr(IDX_ULINE, ul);
    wr(IDX_MODE, md);
    wr(IDX_MEMCFG, cfg);
    wait_frames(1);
    for (k = 0; k < 300 && !display_en; k++) begin
      @(posedge clk_sys);
      #10;
    end
    if (display_en !== 1'b1) begin
      err_count++;
      $display("BAD %0t active wait ran out", $time);
      complete_run();
    end
    check(16'(mem_addr), a0, "first address");
    n = 0;
    for (k = 0; k < 252; k++) begin
      if (k == 2) begin
        check(16'(mem_addr), a1, "third address");
      end
      n = n + int'(underline);
      @(posedge clk_sys);
      #10;
    end
    check(16'(n), 16'd8, "underline cycles");
  endtask
  // Start at 10h; address on the first and third active clock in each addressing mode
  task automatic test_addr();
    wr(IDX_ADDR_EXT, 8'h00);
    wr(IDX_START_LO, 8'h10);
    addr_case(8'h01, 8'h00, 8'h00, 16'h0010, 16'h0012);
    addr_case(8'h01, 8'h08, 8'h00, 16'h0020, 16'h0022);
    addr_case(8'h41, 8'h00, 8'h00, 16'h0040, 16'h0048);
    addr_case(8'h61, 8'h00, 8'h00, 16'h0080, 16'h0080);
    addr_case(8'h61, 8'h00, 8'h08, 16'h0040, 16'h0040);
    $display("addr test ended");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    reg_index = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    repeat (10) @(posedge clk_sys);
    #10;
    rst_n = 1'b1;
    @(posedge clk_sys);
    #10;
    test_regs();
    test_lock();
    test_vsync();
    test_irq();
    test_refresh();
    test_cursor();
    test_addr();
    complete_run();
  end
endmodule
`default_nettype wire

// ==== cvc_monitor.sv ====
`default_nettype none
module cvc_monitor (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic vsync,
  input wire logic display_en,
  input wire logic cursor,
  output logic [15:0] frame_len,
  output logic [15:0] vs_width,
  output logic [15:0] vs_lead,
  output logic [15:0] de_cycles,
  output logic [15:0] cur_cycles,
  output logic [15:0] cur_pos,
  output logic [15:0] frames
);
  timeunit 1ns;
  timeprecision 1ns;
  logic vs_q;
  logic de_q;
  logic cur_q;
  logic lead_done;
  logic [15:0] cnt_frame;
  logic [15:0] cnt_vs;
  logic [15:0] cnt_de;
  logic [15:0] cnt_cur;
  logic [15:0] cnt_line;
  ////////////////////////////////////////////////////////////////////////////
  // Passive screen: only measures what the tube would see
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      {vs_q, de_q, cur_q, lead_done} <= 4'h0;
      {frame_len, vs_width, vs_lead, de_cycles} <= 64'h0;
      {cur_cycles, cur_pos, frames, cnt_frame} <= 64'h0;
      {cnt_vs, cnt_de, cnt_cur, cnt_line} <= 64'h0;
    end else begin
      vs_q <= vsync;
      de_q <= display_en;
      cur_q <= cursor;
      cnt_line <= (display_en && !de_q) ? 16'h0001 : cnt_line + 16'h0001;
      if (cursor && !cur_q) begin
        cur_pos <= cnt_line;
      end
      if (display_en && !de_q && !lead_done) begin
        vs_lead <= cnt_frame;
        lead_done <= 1'b1;
      end
      cnt_vs <= vsync ? cnt_vs + 16'h0001 : 16'h0000;
      if (!vsync && vs_q) begin
        vs_width <= cnt_vs;
      end
      if (vsync && !vs_q) begin
        frame_len <= cnt_frame;
        de_cycles <= cnt_de;
        cur_cycles <= cnt_cur;
        frames <= frames + 16'h0001;
        cnt_frame <= 16'h0001;
        cnt_de <= {15'h0000, display_en};
        cnt_cur <= {15'h0000, cursor};
        lead_done <= 1'b0;
      end else begin
        cnt_frame <= cnt_frame + 16'h0001;
        cnt_de <= cnt_de + {15'h0000, display_en};
        cnt_cur <= cnt_cur + {15'h0000, cursor};
      end
    end
  end
endmodule
`default_nettype wire

// ==== cvc_pkg.sv ====
`default_nettype none
package cvc_pkg;
  // Indices of the indexed CRT register space
  localparam logic [7:0] IDX_VTOTAL = 8'h06;
  localparam logic [7:0] IDX_OVFL = 8'h07;
  localparam logic [7:0] IDX_MAXSCAN = 8'h09;
  localparam logic [7:0] IDX_CUR_START = 8'h0A;
  localparam logic [7:0] IDX_CUR_END = 8'h0B;
  localparam logic [7:0] IDX_START_HI = 8'h0C;
  localparam logic [7:0] IDX_START_LO = 8'h0D;
  localparam logic [7:0] IDX_CUR_HI = 8'h0E;
  localparam logic [7:0] IDX_CUR_LO = 8'h0F;
  localparam logic [7:0] IDX_VS_START = 8'h10;
  localparam logic [7:0] IDX_VS_END = 8'h11;
  localparam logic [7:0] IDX_VDE = 8'h12;
  localparam logic [7:0] IDX_OFFSET = 8'h13;
  localparam logic [7:0] IDX_ULINE = 8'h14;
  localparam logic [7:0] IDX_MODE = 8'h17;
  localparam logic [7:0] IDX_MEMCFG = 8'h31;
  localparam logic [7:0] IDX_SYSCFG = 8'h32;
  localparam logic [7:0] IDX_REFOVR = 8'h3A;
  localparam logic [7:0] IDX_EXTMODE = 8'h43;
  localparam logic [7:0] IDX_PITCH_EXT = 8'h51;
  localparam logic [7:0] IDX_VEXT = 8'h5E;
  localparam logic [7:0] IDX_ADDR_EXT = 8'h69;
  localparam logic [7:0] IDX_LOCK_LAST = 8'h07;

  // Storage slots
  localparam int NUM_SLOTS = 22;
  localparam logic [4:0] SL_VTOTAL = 5'h00;
  localparam logic [4:0] SL_OVFL = 5'h01;
  localparam logic [4:0] SL_MAXSCAN = 5'h02;
  localparam logic [4:0] SL_CUR_START = 5'h03;
  localparam logic [4:0] SL_CUR_END = 5'h04;
  localparam logic [4:0] SL_START_HI = 5'h05;
  localparam logic [4:0] SL_START_LO = 5'h06;
  localparam logic [4:0] SL_CUR_HI = 5'h07;
  localparam logic [4:0] SL_CUR_LO = 5'h08;
  localparam logic [4:0] SL_VS_START = 5'h09;
  localparam logic [4:0] SL_VS_END = 5'h0A;
  localparam logic [4:0] SL_VDE = 5'h0B;
  localparam logic [4:0] SL_OFFSET = 5'h0C;
  localparam logic [4:0] SL_ULINE = 5'h0D;
  localparam logic [4:0] SL_MODE = 5'h0E;
  localparam logic [4:0] SL_MEMCFG = 5'h0F;
  localparam logic [4:0] SL_SYSCFG = 5'h10;
  localparam logic [4:0] SL_REFOVR = 5'h11;
  localparam logic [4:0] SL_EXTMODE = 5'h12;
  localparam logic [4:0] SL_PITCH_EXT = 5'h13;
  localparam logic [4:0] SL_VEXT = 5'h14;
  localparam logic [4:0] SL_ADDR_EXT = 5'h15;

  // Field positions
  localparam int B_CUR_OFF = 5;
  localparam int B_VINT_CLR = 4;
  localparam int B_VINT_DIS = 5;
  localparam int B_REF5 = 6;
  localparam int B_LOCK = 7;
  localparam int B_CNT4 = 5;
  localparam int B_DWORD = 6;
  localparam int B_CNT2 = 3;
  localparam int B_FORCE_DW = 3;
  localparam int B_GIE = 4;
  localparam int B_PITCH8 = 2;
  localparam int B_OVF_VT8 = 0;
  localparam int B_OVF_VDE8 = 1;
  localparam int B_OVF_VRS8 = 2;
  localparam int B_OVF_VT9 = 5;
  localparam int B_OVF_VDE9 = 6;
  localparam int B_OVF_VRS9 = 7;
  localparam int B_EXT_VT10 = 0;
  localparam int B_EXT_VDE10 = 1;
  localparam int B_EXT_VRS10 = 4;

  // Reset value and writable-bit masks
  localparam logic [7:0] RST_REG = 8'h00;
  localparam logic [7:0] MASK_FULL = 8'hFF;
  localparam logic [7:0] MASK_CUR_START = 8'h3F;
  localparam logic [7:0] MASK_CUR_END = 8'h7F;
  localparam logic [7:0] MASK_ULINE = 8'h7F;
  localparam logic [7:0] MASK_MODE = 8'hEF;
  localparam logic [7:0] MASK_SPLIT8 = 8'h10;
  localparam logic [7:0] MASK_NONE = 8'h00;

  localparam logic [2:0] REFRESH_FEW = 3'h3;
  localparam logic [2:0] REFRESH_MANY = 3'h5;

  typedef enum logic [1:0] {AM_BYTE, AM_WORD, AM_DWORD, AM_QWORD} cvc_addr_mode_t;
endpackage
`default_nettype wire
